// file: rtl/lcdsl_defs.vh
// Summary of operation
// - shift clock high for high count plus one
// - mode bit six picks memory base and mode
// - double bit sends each 200-line row twice
// - line clock rises rise count plus one later
// - type 00 runs shift clock continuously
// - nonzero type suppresses four pulses per line
// - types 10/11 add one/two shift periods delay
// - period lasts period count plus one, minimum two
// - line clock falls fall count plus one later, one shift period more with the extend bit
`ifndef LCDSL_DEFS_VH
`define LCDSL_DEFS_VH

// register indices; byte address is four times the index
`define LCDSL_IDX_PERIOD 8'hC6
`define LCDSL_IDX_HIGH 8'hC7
`define LCDSL_IDX_RISE 8'hC8
`define LCDSL_IDX_SHAPE 8'hC9
`define LCDSL_IDX_LINE_LEN 8'hD0
`define LCDSL_IDX_STATUS 8'hD1

// field positions
`define LCDSL_PRESCALE_MSB 7
`define LCDSL_PRESCALE_LSB 5
`define LCDSL_COUNT_MSB 4
`define LCDSL_GFX_MODE_BIT 6
`define LCDSL_DOUBLE_BIT 5
`define LCDSL_TYPE_MSB 7
`define LCDSL_TYPE_LSB 6
`define LCDSL_EXTEND_BIT 5

// reset values
`define LCDSL_REG_RESET 8'h00

// timing figures
`define LCDSL_SUPPRESS_PULSES 8'h04
`define LCDSL_MIN_PERIOD_LAST 5'h01
`define LCDSL_BASE_CGA 20'hB8000

// axi responses
`define LCDSL_RESP_OKAY 2'h0
`define LCDSL_RESP_SLVERR 2'h2

`endif

// file: rtl/lcdsl_prescale.v
`timescale 1ns/1ps
`include "lcdsl_defs.vh"

// one-cycle tick every 2**sel core clocks: the internal pixel clock
module lcdsl_prescale (
    input wire clk,
    input wire rst_b,
    input wire [2:0] sel,
    output reg tick
);
    reg [6:0] cnt_q;
    wire [6:0] last = (7'h01 << sel) - 7'h01;

    always @(posedge clk) begin
        if (!rst_b) begin
            cnt_q <= 7'h00;
            tick <= 1'b0;
        end else begin
            // a shrunk divisor may leave cnt above last; >= recovers at once
            if (cnt_q >= last) begin
                cnt_q <= 7'h00;
                tick <= 1'b1;
            end else begin
                cnt_q <= cnt_q + 7'h01;
                tick <= 1'b0;
            end
        end
    end
endmodule

// file: rtl/lcdsl_top.v
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
`include "lcdsl_defs.vh"

module lcdsl_top #(
    parameter ROWS_CGA = 9'd200,
    parameter ROWS_VGA = 9'd480,
    parameter [19:0] BASE_VGA = 20'hA0000
) (
    input wire CORE_CLK,
    input wire RST_B,
    input wire [11:0] S_AXI_AWADDR,
    input wire S_AXI_AWVALID,
    output reg S_AXI_AWREADY,
    input wire [31:0] S_AXI_WDATA,
    input wire [3:0] S_AXI_WSTRB,
    input wire S_AXI_WVALID,
    output reg S_AXI_WREADY,
    output reg [1:0] S_AXI_BRESP,
    output reg S_AXI_BVALID,
    input wire S_AXI_BREADY,
    input wire [11:0] S_AXI_ARADDR,
    input wire S_AXI_ARVALID,
    output reg S_AXI_ARREADY,
    output reg [31:0] S_AXI_RDATA,
    output reg [1:0] S_AXI_RRESP,
    output reg S_AXI_RVALID,
    input wire S_AXI_RREADY,
    output reg SHIFT_CLOCK,
    output reg LINE_CLOCK,
    output reg [8:0] SOURCE_ROW,
    output reg [19:0] DISPLAY_BASE
);
    ////////////////////////////////////////////////////////////////////////
    // register file
    reg [7:0] period_q;
    reg [7:0] high_q;
    reg [7:0] rise_q;
    reg [7:0] shape_q;
    reg [7:0] len_q;
    reg [7:0] aw_idx_q;
    reg aw_have_q;
    reg [7:0] w_data_q;
    reg w_lane_q;
    reg w_have_q;

    wire [4:0] t1 = period_q[`LCDSL_COUNT_MSB:0];
    wire [4:0] t2 = high_q[`LCDSL_COUNT_MSB:0];
    wire [4:0] t3 = rise_q[`LCDSL_COUNT_MSB:0];
    wire [4:0] t4 = shape_q[`LCDSL_COUNT_MSB:0];
    wire gfx_vga = rise_q[`LCDSL_GFX_MODE_BIT];
    wire line_double = rise_q[`LCDSL_DOUBLE_BIT];
    wire [1:0] line_clock_type = shape_q[`LCDSL_TYPE_MSB:`LCDSL_TYPE_LSB];
    wire line_fall_extend = shape_q[`LCDSL_EXTEND_BIT];

    wire aw_take = S_AXI_AWVALID && S_AXI_AWREADY;
    wire w_take = S_AXI_WVALID && S_AXI_WREADY;
    wire [7:0] wr_idx = aw_take ? S_AXI_AWADDR[9:2] : aw_idx_q;
    wire [7:0] wr_data = w_take ? S_AXI_WDATA[7:0] : w_data_q;
    wire wr_lane = w_take ? S_AXI_WSTRB[0] : w_lane_q;
    wire wr_go = (aw_take || aw_have_q) && (w_take || w_have_q) && !S_AXI_BVALID;
    wire wr_hit = (wr_idx == `LCDSL_IDX_PERIOD) || (wr_idx == `LCDSL_IDX_HIGH) ||
                  (wr_idx == `LCDSL_IDX_RISE) || (wr_idx == `LCDSL_IDX_SHAPE) ||
                  (wr_idx == `LCDSL_IDX_LINE_LEN);

    always @(posedge CORE_CLK) begin
        if (!RST_B) begin
            period_q <= `LCDSL_REG_RESET;
            high_q <= `LCDSL_REG_RESET;
            rise_q <= `LCDSL_REG_RESET;
            shape_q <= `LCDSL_REG_RESET;
            len_q <= `LCDSL_REG_RESET;
            aw_idx_q <= 8'h00;
            aw_have_q <= 1'b0;
            w_data_q <= 8'h00;
            w_lane_q <= 1'b0;
            w_have_q <= 1'b0;
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY <= 1'b0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= `LCDSL_RESP_OKAY;
        end else begin
            // hold each half until the pair is complete and the response is free
            S_AXI_AWREADY <= !aw_have_q && !aw_take && !wr_go && !S_AXI_BVALID;
            S_AXI_WREADY <= !w_have_q && !w_take && !wr_go && !S_AXI_BVALID;
            if (aw_take) begin
                aw_idx_q <= S_AXI_AWADDR[9:2];
            end
            if (w_take) begin
                w_data_q <= S_AXI_WDATA[7:0];
                w_lane_q <= S_AXI_WSTRB[0];
            end
            if (wr_go) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP <= wr_hit ? `LCDSL_RESP_OKAY : `LCDSL_RESP_SLVERR;
                if (wr_lane) begin
                    case (wr_idx)
                        `LCDSL_IDX_PERIOD: period_q <= wr_data;
                        `LCDSL_IDX_HIGH: high_q <= {1'b0, wr_data[6:0]};
                        `LCDSL_IDX_RISE: rise_q <= {1'b0, wr_data[6:0]};
                        `LCDSL_IDX_SHAPE: shape_q <= wr_data;
                        `LCDSL_IDX_LINE_LEN: len_q <= wr_data;
                        default: ;
                    endcase
                end
            end else begin
                if (aw_take) begin
                    aw_have_q <= 1'b1;
                end
                if (w_take) begin
                    w_have_q <= 1'b1;
                end
                if (S_AXI_BVALID && S_AXI_BREADY) begin
                    S_AXI_BVALID <= 1'b0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read channel
    reg dbl_phase_q;
    reg in_sup_q;
    reg [31:0] rd_word;
    reg rd_hit;

    always @* begin
        rd_word = 32'h00000000;
        rd_hit = 1'b1;
        case (S_AXI_ARADDR[9:2])
            `LCDSL_IDX_PERIOD: rd_word = {24'h000000, period_q};
            `LCDSL_IDX_HIGH: rd_word = {24'h000000, high_q};
            `LCDSL_IDX_RISE: rd_word = {24'h000000, rise_q};
            `LCDSL_IDX_SHAPE: rd_word = {24'h000000, shape_q};
            `LCDSL_IDX_LINE_LEN: rd_word = {24'h000000, len_q};
            `LCDSL_IDX_STATUS: rd_word = {19'h00000, in_sup_q, LINE_CLOCK,
                                          SHIFT_CLOCK, dbl_phase_q, SOURCE_ROW};
            default: rd_hit = 1'b0;
        endcase
    end

    always @(posedge CORE_CLK) begin
        if (!RST_B) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= 32'h00000000;
            S_AXI_RRESP <= `LCDSL_RESP_OKAY;
        end else begin
            S_AXI_ARREADY <= !S_AXI_RVALID && !S_AXI_ARREADY;
            if (S_AXI_ARVALID && S_AXI_ARREADY) begin
                S_AXI_RVALID <= 1'b1;
                S_AXI_RDATA <= rd_word;
                S_AXI_RRESP <= rd_hit ? `LCDSL_RESP_OKAY : `LCDSL_RESP_SLVERR;
            end else if (S_AXI_RVALID && S_AXI_RREADY) begin
                S_AXI_RVALID <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pixel clock
    wire pix_tick;

    lcdsl_prescale u_prescale (
        .clk(CORE_CLK),
        .rst_b(RST_B),
        .sel(period_q[`LCDSL_PRESCALE_MSB:`LCDSL_PRESCALE_LSB]),
        .tick(pix_tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // shift and line clock sequencing, all stepped by pix_tick
    reg [4:0] ph_q;
    reg [8:0] slot_q;
    reg [7:0] lc_cnt_q;
    reg lc_run_q;
    // line level in phase time; the pin copies it one clock later like the shift clock
    reg lc_lvl_q;

    // period count below one would give a one-clock period
    wire [4:0] ph_last = (t1 < `LCDSL_MIN_PERIOD_LAST) ? `LCDSL_MIN_PERIOD_LAST : t1;
    wire suppress = (line_clock_type != 2'b00);
    wire [8:0] slot_last = {1'b0, len_q} +
                           (suppress ? {1'b0, `LCDSL_SUPPRESS_PULSES} : 9'h000);
    wire in_sup = (slot_q > {1'b0, len_q});
    // reference rise: last real pulse, or first suppressed one
    wire [8:0] ref_slot = {1'b0, len_q} + (suppress ? 9'h001 : 9'h000);
    wire [7:0] per_len = {3'b000, ph_last} + 8'h01;
    wire [7:0] extra = (line_clock_type == 2'b10) ? per_len :
                       (line_clock_type == 2'b11) ? {per_len[6:0], 1'b0} : 8'h00;
    wire [7:0] rise_at = {3'b000, t3} + 8'h01 + extra;
    wire [7:0] fall_at = {3'b000, t4} + 8'h01 + extra +
                         (line_fall_extend ? per_len : 8'h00);
    wire line_end = pix_tick && (ph_q == ph_last) && (slot_q >= slot_last);
    wire [7:0] lc_cnt_n = (ph_q == 5'h00 && slot_q == ref_slot) ? 8'h01 :
                          lc_cnt_q + 8'h01;
    wire lc_step = pix_tick && (lc_run_q || (ph_q == 5'h00 && slot_q == ref_slot));
    wire [8:0] row_last = gfx_vga ? ROWS_VGA - 9'd1 : ROWS_CGA - 9'd1;

    always @(posedge CORE_CLK) begin
        if (!RST_B) begin
            ph_q <= 5'h00;
            slot_q <= 9'h000;
            lc_cnt_q <= 8'h00;
            lc_run_q <= 1'b0;
            lc_lvl_q <= 1'b0;
            in_sup_q <= 1'b0;
            dbl_phase_q <= 1'b0;
            SHIFT_CLOCK <= 1'b0;
            LINE_CLOCK <= 1'b0;
            SOURCE_ROW <= 9'h000;
            DISPLAY_BASE <= `LCDSL_BASE_CGA;
        end else begin
            if (pix_tick) begin
                if (ph_q >= ph_last) begin
                    ph_q <= 5'h00;
                    slot_q <= (slot_q >= slot_last) ? 9'h000 : slot_q + 9'h001;
                end else begin
                    ph_q <= ph_q + 5'h01;
                end
            end
            // output trails phase state by one core clock, uniformly
            SHIFT_CLOCK <= (ph_q <= t2) && !in_sup;
            in_sup_q <= in_sup;
            if (lc_step) begin
                lc_cnt_q <= lc_cnt_n;
                lc_run_q <= (lc_cnt_n < fall_at);
                if (lc_cnt_n == rise_at) begin
                    lc_lvl_q <= 1'b1;
                end
                if (lc_cnt_n == fall_at) begin
                    lc_lvl_q <= 1'b0;
                end
            end
            LINE_CLOCK <= lc_lvl_q;
            if (line_end) begin
                // 640x200 rows repeat only in the non-vga mode
                if (line_double && !gfx_vga && !dbl_phase_q) begin
                    dbl_phase_q <= 1'b1;
                end else begin
                    dbl_phase_q <= 1'b0;
                    SOURCE_ROW <= (SOURCE_ROW >= row_last) ? 9'h000 : SOURCE_ROW + 9'h001;
                end
            end
            DISPLAY_BASE <= gfx_vga ? BASE_VGA : `LCDSL_BASE_CGA;
        end
    end
endmodule

// file: verif/lcdsl_chk.sv
`timescale 1ns/1ps
module lcdsl_chk #(
    parameter ROWS_VGA = 9'd480,
    parameter [19:0] BASE_VGA = 20'hA0000
) (
    input wire CORE_CLK,
    input wire RST_B,
    input wire S_AXI_AWREADY,
    input wire S_AXI_WREADY,
    input wire [1:0] S_AXI_BRESP,
    input wire S_AXI_BVALID,
    input wire S_AXI_BREADY,
    input wire S_AXI_ARVALID,
    input wire S_AXI_ARREADY,
    input wire [31:0] S_AXI_RDATA,
    input wire S_AXI_RVALID,
    input wire S_AXI_RREADY,
    input wire SHIFT_CLOCK,
    input wire LINE_CLOCK,
    input wire [8:0] SOURCE_ROW,
    input wire [19:0] DISPLAY_BASE
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RST_B);
    AST_RST_OUT: assert property ($rose(RST_B) |-> !SHIFT_CLOCK && !LINE_CLOCK
        && SOURCE_ROW == 9'h000 && DISPLAY_BASE == 20'hB8000) else $error("not idle after reset");
    AST_BASE_SEL: assert property (DISPLAY_BASE == 20'hB8000 || DISPLAY_BASE == BASE_VGA)
        else $error("display base not a mode base");
    AST_ROW_RANGE: assert property (SOURCE_ROW < ROWS_VGA)
        else $error("source row out of range");
    AST_RDATA_HIGH: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:13] == 19'h00000)
        else $error("read data upper bits set");
    AST_R_LAT: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID && !S_AXI_ARREADY)
        else $error("read answer late");
    AST_B_READY_LOW: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
        else $error("write ready during response");
    AST_B_DONE: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
        else $error("write response repeated");
    AST_R_DONE: assert property (S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID)
        else $error("read response repeated");
    cover property ($rose(LINE_CLOCK));
    cover property (S_AXI_BVALID && S_AXI_BRESP == 2'h2);
    cover property ($changed(SOURCE_ROW));
endmodule
bind lcdsl_top lcdsl_chk #(.ROWS_VGA(ROWS_VGA), .BASE_VGA(BASE_VGA)) lcdsl_chk_i (.*);

// file: verif/lcdsl_panel_model.sv
`timescale 1ns/1ps
// passive panel: measures shift and line clock shapes in core clocks
module lcdsl_panel_model (
    input wire clk,
    input wire shift_clock,
    input wire line_clock,
    input wire [8:0] source_row,
    output reg [7:0] high_len,
    output reg [7:0] period_len,
    output reg [7:0] gap_len,
    output reg [7:0] rise_delay,
    output reg [7:0] line_high,
    output reg [7:0] row_lines
);
    reg sh_q = 1'b0, ln_q = 1'b0, gap_q = 1'b0;
    reg [8:0] row_q = 9'h000;
    reg [7:0] since_q = 8'h00, lhi_q = 8'h00, cnt_q = 8'h00;
    wire ln_rise = line_clock && !ln_q;
    always @(posedge clk) begin
        sh_q <= shift_clock;
        ln_q <= line_clock;
        row_q <= source_row;
        since_q <= since_q + 8'h01;
        lhi_q <= lhi_q + 8'h01;
        if (shift_clock && !sh_q) begin
            since_q <= 8'h01;
            period_len <= since_q;
            if (gap_q) gap_len <= since_q;
            gap_q <= 1'b0;
        end
        if (sh_q && !shift_clock) high_len <= since_q;
        if (ln_rise) begin
            rise_delay <= since_q;
            lhi_q <= 8'h01;
            gap_q <= 1'b1;
        end
        if (ln_q && !line_clock) line_high <= lhi_q;
        // a line edge on the row change edge still counts for the new row
        if (row_q != source_row) begin
            row_lines <= cnt_q;
            cnt_q <= {7'h00, ln_rise};
        end else if (ln_rise) cnt_q <= cnt_q + 8'h01;
    end
endmodule

// file: verif/test_lcdsl_top.sv
`timescale 1ns/1ps
module test_lcdsl_top;
    reg core_clk = 1'b0, rst_b = 1'b0;
    reg [11:0] aw_addr = 12'h000, ar_addr = 12'h000;
    reg [31:0] w_data = 32'h00000000;
    reg [3:0] w_strb = 4'hF;
    reg aw_valid = 1'b0, w_valid = 1'b0, b_ready = 1'b0, ar_valid = 1'b0, r_ready = 1'b0;
    wire aw_ready, w_ready, b_valid, ar_ready, r_valid, shift_clock, line_clock;
    wire [1:0] b_resp, r_resp;
    wire [31:0] r_data;
    wire [8:0] source_row;
    wire [19:0] display_base;
    wire [7:0] high_len, period_len, gap_len, rise_delay, line_high, row_lines;
    integer bad_count = 0, check_count = 0, t;
    initial forever #12.5 core_clk = ~core_clk;
    lcdsl_top lcdsl_top_i (.CORE_CLK(core_clk), .RST_B(rst_b), .S_AXI_AWADDR(aw_addr),
        .S_AXI_AWVALID(aw_valid), .S_AXI_AWREADY(aw_ready), .S_AXI_WDATA(w_data),
        .S_AXI_WSTRB(w_strb), .S_AXI_WVALID(w_valid), .S_AXI_WREADY(w_ready),
        .S_AXI_BRESP(b_resp), .S_AXI_BVALID(b_valid), .S_AXI_BREADY(b_ready),
        .S_AXI_ARADDR(ar_addr), .S_AXI_ARVALID(ar_valid), .S_AXI_ARREADY(ar_ready),
        .S_AXI_RDATA(r_data), .S_AXI_RRESP(r_resp), .S_AXI_RVALID(r_valid),
        .S_AXI_RREADY(r_ready), .SHIFT_CLOCK(shift_clock), .LINE_CLOCK(line_clock),
        .SOURCE_ROW(source_row), .DISPLAY_BASE(display_base));
    lcdsl_panel_model lcdsl_panel_model_i (.clk(core_clk), .shift_clock(shift_clock),
        .line_clock(line_clock), .source_row(source_row), .high_len(high_len),
        .period_len(period_len), .gap_len(gap_len), .rise_delay(rise_delay),
        .line_high(line_high), .row_lines(row_lines));
    ////////////////////////////////////////////////////////////////////////////////
    task chk(input [31:0] got, input [31:0] exp);
        begin
            check_count = check_count + 1;
            if (got !== exp) begin
                bad_count = bad_count + 1;
                $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task end_sim;
        begin
            $display("checks=%0d mismatches=%0d", check_count, bad_count);
            if (bad_count == 0 && check_count > 0) $display("NO MISMATCHES");
            else $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    task hang;
        begin
            chk(32'h0, 32'h1);
            end_sim;
        end
    endtask
    // both channels offered at once; bready held so the answer is taken on sight
    task wr(input [7:0] idx, input [7:0] val, input [1:0] er);
        integer n;
        begin
            @(posedge core_clk);
            aw_addr <= {2'b00, idx, 2'b00};
            w_data <= {24'h000000, val};
            aw_valid <= 1'b1;
            w_valid <= 1'b1;
            b_ready <= 1'b1;
            n = 0;
            do begin
                @(posedge core_clk);
                n = n + 1;
                if (aw_ready) aw_valid <= 1'b0;
                if (w_ready) w_valid <= 1'b0;
            end while (!b_valid && n < 100);
            b_ready <= 1'b0;
            if (n >= 100) hang;
            chk({30'h0, b_resp}, {30'h0, er});
        end
    endtask
    task rd(input [7:0] idx, input [31:0] ev, input [1:0] er);
        integer n;
        begin
            @(posedge core_clk);
            ar_addr <= {2'b00, idx, 2'b00};
            ar_valid <= 1'b1;
            r_ready <= 1'b1;
            n = 0;
            do begin
                @(posedge core_clk);
                n = n + 1;
                if (ar_ready) ar_valid <= 1'b0;
            end while (!r_valid && n < 100);
            r_ready <= 1'b0;
            if (n >= 100) hang;
            chk(r_data, ev);
            chk({30'h0, r_resp}, {30'h0, er});
        end
    endtask
    task settle;
        repeat (300) @(posedge core_clk);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge core_clk);
        rst_b <= 1'b1;
        for (t = 0; t < 5; t = t + 1) rd(t == 4 ? 8'hD0 : 8'hC6 + t[7:0], 32'h0, 2'h0);
        rd(8'h3F, 32'h0, 2'h2);
        wr(8'h3F, 8'h55, 2'h2);
        wr(8'hD1, 8'h55, 2'h2);
        // lane zero off: accepted, nothing stored
        w_strb <= 4'h0;
        wr(8'hC9, 8'h55, 2'h0);
        w_strb <= 4'hF;
        rd(8'hC9, 32'h0, 2'h0);
        wr(8'hC8, 8'hC0, 2'h0);
        rd(8'hC8, 32'h40, 2'h0);
        chk({12'h000, display_base}, 32'hA0000);
        wr(8'hC6, 8'h05, 2'h0);
        wr(8'hC7, 8'h02, 2'h0);
        wr(8'hC8, 8'h01, 2'h0);
        wr(8'hD0, 8'h03, 2'h0);
        chk({12'h000, display_base}, 32'hB8000);
        for (t = 0; t < 4; t = t + 1) begin
            wr(8'hC9, {t[1:0], 6'h03}, 2'h0);
            settle;
            chk({24'h0, high_len}, 32'd3);
            chk({24'h0, rise_delay}, 2 + 6 * t);
            chk({24'h0, gap_len}, t == 0 ? 32'd6 : 32'd30);
            chk({24'h0, line_high}, 32'd2);
        end
        wr(8'hC9, 8'h23, 2'h0);
        settle;
        chk({24'h0, line_high}, 32'd8);
        chk({24'h0, period_len}, 32'd6);
        wr(8'hC6, 8'h25, 2'h0);
        settle;
        chk({24'h0, period_len}, 32'd12);
        chk({24'h0, high_len}, 32'd6);
        chk({24'h0, rise_delay}, 32'd4);
        wr(8'hC8, 8'h21, 2'h0);
        settle;
        chk({24'h0, row_lines}, 32'd2);
        wr(8'hC8, 8'h01, 2'h0);
        settle;
        chk({24'h0, row_lines}, 32'd1);
        end_sim;
    end
endmodule
